// ===== pkg/bififo_pkg.sv
package bififo_pkg;
  // Port widths and buffer geometry
  localparam int DATA_W      = 18;
  localparam int DEPTH_DEF   = 256;
  localparam int OFFSET_DEF  = 8;
  localparam int RUN_W       = 9;
  // Register byte offsets
  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] AB_AE_ADDR     = 8'h04;
  localparam logic [7:0] AB_AF_ADDR     = 8'h08;
  localparam logic [7:0] BA_AE_ADDR     = 8'h0c;
  localparam logic [7:0] BA_AF_ADDR     = 8'h10;
  localparam logic [7:0] STATUS_ADDR    = 8'h14;
  localparam logic [7:0] IRQ_STAT_ADDR  = 8'h18;
  localparam logic [7:0] IRQ_MASK_ADDR  = 8'h1c;
  // Field positions
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int STAT_FLAGS_LSB  = 0;
  localparam int STAT_AB_CNT_LSB = 9;
  localparam int STAT_BA_CNT_LSB = 20;
  localparam int IRQ_W           = 4;
  localparam int IRQ_AB_WR_BIT   = 0;
  localparam int IRQ_AB_RD_BIT   = 1;
  localparam int IRQ_BA_WR_BIT   = 2;
  localparam int IRQ_BA_RD_BIT   = 3;
  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic             BYPASS_RST   = 1'b0;
endpackage

// ===== logic/bififo_port_b.sv
// Contract
// - Port B data is sampled and updated only on rising port B clock edges.
// - No port B read or write happens while the port B enable is high.
// - Port B data is driven only when direction is read and output enable low.
// - A-to-B empty flag low when empty; port B reads are then ignored.
// - Bypass: A-to-B empty flag high while a port A word waits, low after read.
// - Almost-empty flags low while count is at or below the offset, default 8.
// - Almost-full flags low while count exceeds depth minus offset, default 8.
// - Empty flags follow the reading port clock, full flags the writing port clock.
// - A-to-B full flag low when full; port A writes are then ignored.
// - Bypass: A-to-B full flag low while a port A message waits for port B.
// - B-to-A empty flag low when empty; port A reads are then ignored.
// - Bypass: B-to-A empty flag high while a word waits, low from the A edge of the read.
// - B-to-A full flag low when full; port B writes are then ignored.
// - Bypass: B-to-A full flag low while a port B message waits for port A.
// - Port B bypass indicator low in bypass mode, high otherwise, on port B clock.
// - Reset low reinitialises buffers, flags and bypass state.
// - Port B direction low writes, high reads; in bypass it selects the message registers.
// - Port A resources including offsets are selected over the register bus here.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module bififo_port_b
#(
  parameter int DEPTH = bififo_pkg::DEPTH_DEF
)
(
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          clk_en,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic                               irq,
  input  wire logic                          port_a_clock,
  input  wire logic                          port_a_select_n,
  input  wire logic                          port_a_direction,
  input  wire logic [bififo_pkg::DATA_W-1:0] port_a_data_in,
  output logic      [bififo_pkg::DATA_W-1:0] port_a_data_out,
  output logic                               port_a_data_oe_n,
  input  wire logic                          port_b_clock,
  input  wire logic                          port_b_enable_n,
  input  wire logic                          port_b_direction,
  input  wire logic                          port_b_output_enable_n,
  input  wire logic [bififo_pkg::DATA_W-1:0] port_b_data_in,
  output logic      [bififo_pkg::DATA_W-1:0] port_b_data_out,
  output logic                               port_b_data_oe_n,
  output logic                               ab_empty_n,
  output logic                               ab_almost_empty_n,
  output logic                               ab_almost_full_n,
  output logic                               ab_full_n,
  output logic                               ba_empty_n,
  output logic                               ba_almost_empty_n,
  output logic                               ba_almost_full_n,
  output logic                               ba_full_n,
  output logic                               port_b_bypass_indicator_n
);
  import bififo_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int BW    = DATA_W + 4;
  localparam int AW    = DATA_W + 3;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] OFF_RST  = CNT_W'(OFFSET_DEF);

  logic [BW-1:0]      b_s1_reg;
  logic [BW-1:0]      b_s2_reg;
  logic               b_clk_d_reg;
  logic [AW-1:0]      a_s1_reg;
  logic [AW-1:0]      a_s2_reg;
  logic               a_clk_d_reg;
  logic               b_edge;
  logic               a_edge;
  logic               b_on;
  logic               b_dir;
  logic               b_oe_n;
  logic [DATA_W-1:0]  b_din;
  logic               a_on;
  logic               a_dir;
  logic [DATA_W-1:0]  a_din;
  logic [DATA_W-1:0]  ab_mem [DEPTH];
  logic [DATA_W-1:0]  ba_mem [DEPTH];
  logic [PTR_W-1:0]   ab_wp_reg;
  logic [PTR_W-1:0]   ab_rp_reg;
  logic [PTR_W-1:0]   ba_wp_reg;
  logic [PTR_W-1:0]   ba_rp_reg;
  logic [CNT_W-1:0]   ab_cnt_reg;
  logic [CNT_W-1:0]   ab_cnt_next;
  logic [CNT_W-1:0]   ba_cnt_reg;
  logic [CNT_W-1:0]   ba_cnt_next;
  logic               bypass_reg;
  logic               ab_msg_reg;
  logic               ba_msg_reg;
  logic [DATA_W-1:0]  ab_msg_data_reg;
  logic [DATA_W-1:0]  ba_msg_data_reg;
  logic [CNT_W-1:0]   ab_ae_reg;
  logic [CNT_W-1:0]   ab_af_reg;
  logic [CNT_W-1:0]   ba_ae_reg;
  logic [CNT_W-1:0]   ba_af_reg;
  logic [IRQ_W-1:0]   irq_stat_reg;
  logic [IRQ_W-1:0]   irq_mask_reg;
  logic [IRQ_W-1:0]   irq_set;
  logic               ab_wr;
  logic               ab_rd;
  logic               ba_wr;
  logic               ba_rd;
  logic               ab_bwr;
  logic               ab_brd;
  logic               ba_bwr;
  logic               ba_brd;
  logic               a_wr_try;
  logic               a_rd_try;
  logic               b_wr_try;
  logic               b_rd_try;
  logic               wr_pend_reg;
  logic [7:0]         wr_addr_reg;
  logic               addr_phase;
  logic [31:0]        rd_mux;

  // Two-flop synchronisers for port pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      b_s1_reg    <= '0;
      b_s2_reg    <= '0;
      b_clk_d_reg <= 1'b0;
      a_s1_reg    <= '0;
      a_s2_reg    <= '0;
      a_clk_d_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      b_s1_reg    <= {port_b_clock, port_b_enable_n, port_b_direction, port_b_output_enable_n, port_b_data_in};
      b_s2_reg    <= b_s1_reg;
      b_clk_d_reg <= b_s2_reg[BW-1];
      a_s1_reg    <= {port_a_clock, port_a_select_n, port_a_direction, port_a_data_in};
      a_s2_reg    <= a_s1_reg;
      a_clk_d_reg <= a_s2_reg[AW-1];
    end
  end

  // Rising port clock edges and qualified controls
  assign b_edge = clk_en & b_s2_reg[BW-1] & ~b_clk_d_reg;
  assign a_edge = clk_en & a_s2_reg[AW-1] & ~a_clk_d_reg;
  assign b_on   = b_edge & ~b_s2_reg[BW-2];
  assign b_dir  = b_s2_reg[BW-3];
  assign b_oe_n = b_s2_reg[BW-4];
  assign b_din  = b_s2_reg[DATA_W-1:0];
  assign a_on   = a_edge & ~a_s2_reg[AW-2];
  assign a_dir  = a_s2_reg[AW-3];
  assign a_din  = a_s2_reg[DATA_W-1:0];

  // Transfer decisions; direction low writes, high reads
  assign a_wr_try = a_on & ~a_dir;
  assign a_rd_try = a_on & a_dir;
  assign b_wr_try = b_on & ~b_dir;
  assign b_rd_try = b_on & b_dir;
  assign ab_wr    = a_wr_try & ~bypass_reg & (ab_cnt_reg != FULL_CNT);
  assign ab_rd    = b_rd_try & ~bypass_reg & (ab_cnt_reg != '0);
  assign ba_wr    = b_wr_try & ~bypass_reg & (ba_cnt_reg != FULL_CNT);
  assign ba_rd    = a_rd_try & ~bypass_reg & (ba_cnt_reg != '0);
  assign ab_bwr   = a_wr_try & bypass_reg & ~ab_msg_reg;
  assign ab_brd   = b_rd_try & bypass_reg & ab_msg_reg;
  assign ba_bwr   = b_wr_try & bypass_reg & ~ba_msg_reg;
  assign ba_brd   = a_rd_try & bypass_reg & ba_msg_reg;

  // Refused transfers raise interrupt events
  assign irq_set[IRQ_AB_WR_BIT] = a_wr_try & ~ab_wr & ~ab_bwr;
  assign irq_set[IRQ_AB_RD_BIT] = b_rd_try & ~ab_rd & ~ab_brd;
  assign irq_set[IRQ_BA_WR_BIT] = b_wr_try & ~ba_wr & ~ba_bwr;
  assign irq_set[IRQ_BA_RD_BIT] = a_rd_try & ~ba_rd & ~ba_brd;

  // Word counts after this cycle's transfers
  assign ab_cnt_next = ab_cnt_reg + CNT_W'(ab_wr) - CNT_W'(ab_rd);
  assign ba_cnt_next = ba_cnt_reg + CNT_W'(ba_wr) - CNT_W'(ba_rd);

  // Buffer storage, written on the writing port's edge
  always_ff @(posedge hclk)
  begin
    if (ab_wr)
      ab_mem[ab_wp_reg] <= a_din;
    if (ba_wr)
      ba_mem[ba_wp_reg] <= b_din;
  end

  // Pointers and counts
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ab_wp_reg  <= '0;
      ab_rp_reg  <= '0;
      ba_wp_reg  <= '0;
      ba_rp_reg  <= '0;
      ab_cnt_reg <= '0;
      ba_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      if (ab_wr)
        ab_wp_reg <= (ab_wp_reg == PTR_W'(DEPTH - 1)) ? '0 : ab_wp_reg + 1'b1;
      if (ab_rd)
        ab_rp_reg <= (ab_rp_reg == PTR_W'(DEPTH - 1)) ? '0 : ab_rp_reg + 1'b1;
      if (ba_wr)
        ba_wp_reg <= (ba_wp_reg == PTR_W'(DEPTH - 1)) ? '0 : ba_wp_reg + 1'b1;
      if (ba_rd)
        ba_rp_reg <= (ba_rp_reg == PTR_W'(DEPTH - 1)) ? '0 : ba_rp_reg + 1'b1;
      ab_cnt_reg <= ab_cnt_next;
      ba_cnt_reg <= ba_cnt_next;
    end
  end

  // Bypass message registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ab_msg_reg      <= 1'b0;
      ba_msg_reg      <= 1'b0;
      ab_msg_data_reg <= '0;
      ba_msg_data_reg <= '0;
    end
    else if (clk_en)
    begin
      if (ab_bwr)
      begin
        ab_msg_reg      <= 1'b1;
        ab_msg_data_reg <= a_din;
      end
      else if (ab_brd)
        ab_msg_reg <= 1'b0;
      if (ba_bwr)
      begin
        ba_msg_reg      <= 1'b1;
        ba_msg_data_reg <= b_din;
      end
      else if (ba_brd)
        ba_msg_reg <= 1'b0;
    end
  end

  // Port B domain flags and data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ab_empty_n                <= 1'b0;
      ab_almost_empty_n         <= 1'b0;
      ba_almost_full_n          <= 1'b1;
      ba_full_n                 <= 1'b1;
      port_b_bypass_indicator_n <= 1'b1;
      port_b_data_out           <= '0;
      port_b_data_oe_n          <= 1'b1;
    end
    else if (b_edge)
    begin
      ab_empty_n                <= bypass_reg ? (ab_msg_reg & ~ab_brd) : (ab_cnt_next != '0);
      ab_almost_empty_n         <= ab_cnt_next > ab_ae_reg;
      ba_almost_full_n          <= ({1'b0, ba_cnt_next} + {1'b0, ba_af_reg}) <= {1'b0, FULL_CNT};
      ba_full_n                 <= bypass_reg ? ~(ba_msg_reg | ba_bwr) : (ba_cnt_next != FULL_CNT);
      port_b_bypass_indicator_n <= ~bypass_reg;
      port_b_data_oe_n          <= ~(b_dir & ~b_oe_n);
      if (ab_rd)
        port_b_data_out <= ab_mem[ab_rp_reg];
      else if (ab_brd)
        port_b_data_out <= ab_msg_data_reg;
    end
  end

  // Port A domain flags and data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ba_empty_n        <= 1'b0;
      ba_almost_empty_n <= 1'b0;
      ab_almost_full_n  <= 1'b1;
      ab_full_n         <= 1'b1;
      port_a_data_out   <= '0;
      port_a_data_oe_n  <= 1'b1;
    end
    else if (a_edge)
    begin
      ba_empty_n        <= bypass_reg ? (ba_msg_reg & ~ba_brd) : (ba_cnt_next != '0);
      ba_almost_empty_n <= ba_cnt_next > ba_ae_reg;
      ab_almost_full_n  <= ({1'b0, ab_cnt_next} + {1'b0, ab_af_reg}) <= {1'b0, FULL_CNT};
      ab_full_n         <= bypass_reg ? ~(ab_msg_reg | ab_bwr) : (ab_cnt_next != FULL_CNT);
      port_a_data_oe_n  <= ~(~a_s2_reg[AW-2] & a_dir);
      if (ba_rd)
        port_a_data_out <= ba_mem[ba_rp_reg];
      else if (ba_brd)
        port_a_data_out <= ba_msg_data_reg;
    end
  end

  // Bus address phase taken when selected and ready
  assign addr_phase = hsel & hready & htrans[1];

  // Read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      CTRL_ADDR:     rd_mux[CTRL_BYPASS_BIT] = bypass_reg;
      AB_AE_ADDR:    rd_mux[CNT_W-1:0] = ab_ae_reg;
      AB_AF_ADDR:    rd_mux[CNT_W-1:0] = ab_af_reg;
      BA_AE_ADDR:    rd_mux[CNT_W-1:0] = ba_ae_reg;
      BA_AF_ADDR:    rd_mux[CNT_W-1:0] = ba_af_reg;
      STATUS_ADDR:
      begin
        rd_mux[STAT_FLAGS_LSB +: 9] = {port_b_bypass_indicator_n, ba_full_n, ba_almost_full_n,
                                       ba_almost_empty_n, ba_empty_n, ab_full_n, ab_almost_full_n,
                                       ab_almost_empty_n, ab_empty_n};
        rd_mux[STAT_AB_CNT_LSB +: CNT_W] = ab_cnt_reg;
        rd_mux[STAT_BA_CNT_LSB +: CNT_W] = ba_cnt_reg;
      end
      IRQ_STAT_ADDR: rd_mux[IRQ_W-1:0] = irq_stat_reg;
      IRQ_MASK_ADDR: rd_mux[IRQ_W-1:0] = irq_mask_reg;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus slave: zero wait state, read data latched in address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase)
        wr_addr_reg <= haddr[7:0];
      if (addr_phase & ~hwrite)
        hrdata <= rd_mux;
    end
  end

  // Software-written control and offset registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bypass_reg   <= BYPASS_RST;
      ab_ae_reg    <= OFF_RST;
      ab_af_reg    <= OFF_RST;
      ba_ae_reg    <= OFF_RST;
      ba_af_reg    <= OFF_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end
    else if (clk_en & wr_pend_reg)
    begin
      case (wr_addr_reg)
        CTRL_ADDR:     bypass_reg <= hwdata[CTRL_BYPASS_BIT];
        AB_AE_ADDR:    ab_ae_reg <= hwdata[CNT_W-1:0];
        AB_AF_ADDR:    ab_af_reg <= hwdata[CNT_W-1:0];
        BA_AE_ADDR:    ba_ae_reg <= hwdata[CNT_W-1:0];
        BA_AF_ADDR:    ba_af_reg <= hwdata[CNT_W-1:0];
        IRQ_MASK_ADDR: irq_mask_reg <= hwdata[IRQ_W-1:0];
        default:       bypass_reg <= bypass_reg;
      endcase
    end
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_pend_reg && wr_addr_reg == IRQ_STAT_ADDR) ?
                       hwdata[IRQ_W-1:0] : '0)) | irq_set;
      irq          <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule // bififo_port_b
`default_nettype wire

// ===== tb/bififo_port_b_chk.sv
`timescale 1ns/10ps
`default_nettype none
module bififo_port_b_chk
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic port_a_clock,
  input wire logic port_b_clock,
  input wire logic port_b_direction,
  input wire logic port_b_output_enable_n,
  input wire logic port_b_data_oe_n,
  input wire logic ab_empty_n,
  input wire logic ab_almost_empty_n,
  input wire logic ab_almost_full_n,
  input wire logic ab_full_n,
  input wire logic ba_empty_n,
  input wire logic ba_almost_empty_n,
  input wire logic ba_almost_full_n,
  input wire logic ba_full_n,
  input wire logic port_b_bypass_indicator_n
);
  logic       pa_reg;
  logic       pb_reg;
  logic [2:0] since_a;
  logic [2:0] since_b;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Cycles since each port clock was last seen rising, saturating
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pa_reg  <= 1'b0;
      pb_reg  <= 1'b0;
      since_a <= 3'h7;
      since_b <= 3'h7;
    end
    else
    begin
      pa_reg  <= port_a_clock;
      pb_reg  <= port_b_clock;
      since_a <= (port_a_clock && !pa_reg) ? 3'h0 : ((since_a == 3'h7) ? 3'h7 : since_a + 3'h1);
      since_b <= (port_b_clock && !pb_reg) ? 3'h0 : ((since_b == 3'h7) ? 3'h7 : since_b + 3'h1);
    end
  end
  a_reset_flags:
    assert property (disable iff (1'b0) !hresetn |-> !ab_empty_n && !ab_almost_empty_n && ab_almost_full_n
      && ab_full_n && !ba_empty_n && !ba_almost_empty_n && ba_almost_full_n && ba_full_n
      && port_b_bypass_indicator_n) else $error("flags not at reset state");
  a_ab_empty_ae:
    assert property (!ab_empty_n |-> !ab_almost_empty_n) else $error("ab empty but not almost empty");
  a_ba_empty_ae:
    assert property (!ba_empty_n |-> !ba_almost_empty_n) else $error("ba empty but not almost empty");
  a_ab_full_af:
    assert property (!ab_full_n && port_b_bypass_indicator_n |-> !ab_almost_full_n)
      else $error("ab full but not almost full");
  a_ba_full_af:
    assert property (!ba_full_n && port_b_bypass_indicator_n |-> !ba_almost_full_n)
      else $error("ba full but not almost full");
  a_b_domain_flags:
    assert property ($changed({ab_empty_n, ab_almost_empty_n, ba_almost_full_n, ba_full_n,
      port_b_bypass_indicator_n}) |-> since_b <= 3'h5) else $error("port B flag moved off a port B edge");
  a_a_domain_flags:
    assert property ($changed({ba_empty_n, ba_almost_empty_n, ab_almost_full_n, ab_full_n})
      |-> since_a <= 3'h5) else $error("port A flag moved off a port A edge");
  a_oe_read_only:
    assert property ($fell(port_b_data_oe_n) |-> port_b_direction && !port_b_output_enable_n)
      else $error("port B data driven outside a read");
  c_ab_full: cover property ($fell(ab_full_n));
  c_ba_full: cover property ($fell(ba_full_n));
  c_bypass: cover property ($fell(port_b_bypass_indicator_n));
  c_b_drive: cover property ($fell(port_b_data_oe_n));
endmodule // bififo_port_b_chk
bind bififo_port_b bififo_port_b_chk i_bififo_port_b_chk
(
  .hclk, .hresetn, .port_a_clock, .port_b_clock, .port_b_direction, .port_b_output_enable_n,
  .port_b_data_oe_n, .ab_empty_n, .ab_almost_empty_n, .ab_almost_full_n, .ab_full_n, .ba_empty_n,
  .ba_almost_empty_n, .ba_almost_full_n, .ba_full_n, .port_b_bypass_indicator_n
);
`default_nettype wire

// ===== tb/bififo_port_a_master.sv
`timescale 1ns/10ps
`default_nettype none
module bififo_port_a_master
(
  input  wire logic                          hclk,
  output logic                               port_a_clock,
  output logic                               port_a_select_n,
  output logic                               port_a_direction,
  output logic      [bififo_pkg::DATA_W-1:0] port_a_data_in,
  input  wire logic [bififo_pkg::DATA_W-1:0] port_a_data_out,
  input  wire logic                          port_a_data_oe_n
);
  import bififo_pkg::*;
  logic [3:0] cnt_a;
  // Idle pins at time zero
  initial
  begin
    cnt_a = 4'h0;
    port_a_clock = 1'b0;
    port_a_select_n = 1'b1;
    port_a_direction = 1'b1;
    port_a_data_in = 18'h0;
  end
  // Free-running port clock, high 5 and low 7 system cycles
  always @(posedge hclk)
  begin
    cnt_a <= (cnt_a == 4'hb) ? 4'h0 : cnt_a + 4'h1;
    port_a_clock <= (cnt_a < 4'h5);
  end
  // One transfer: pins set while the clock is low and held across one rising edge
  task automatic op(input logic dir, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    do @(posedge hclk); while (cnt_a != 4'h8);
    port_a_select_n <= 1'b0;
    port_a_direction <= dir;
    port_a_data_in <= dir ? ~port_a_data_in : d;
    do @(posedge hclk); while (cnt_a != 4'h8);
    q = port_a_data_oe_n ? ~port_a_data_out : port_a_data_out;
    port_a_select_n <= 1'b1;
    port_a_data_in <= ~port_a_data_in;
  endtask
endmodule // bififo_port_a_master
`default_nettype wire

// ===== tb/bififo_port_b_test.sv
`timescale 1ns/10ps
`default_nettype none
module bififo_port_b_test;
  import bififo_pkg::*;
  localparam int DEPTH = 16;
  logic                   hclk;
  logic                   hresetn = 1'b1;
  logic                   clk_en = 1'b1;
  logic                   hsel = 1'b1;
  logic [31:0]            haddr = 32'h0;
  logic [1:0]             htrans = 2'h0;
  logic                   hwrite = 1'b0;
  logic [2:0]             hsize = 3'h2;
  logic [31:0]            hwdata = 32'h0;
  wire logic              hready;
  wire logic [31:0]       hrdata;
  wire logic              hreadyout, hresp, irq;
  wire logic              port_a_clock, port_a_select_n, port_a_direction, port_a_data_oe_n;
  wire logic [DATA_W-1:0] port_a_data_in, port_a_data_out, port_b_data_out;
  logic                   port_b_clock = 1'b0;
  logic                   port_b_enable_n = 1'b1;
  logic                   port_b_direction = 1'b1;
  logic                   port_b_output_enable_n = 1'b1;
  logic [DATA_W-1:0]      port_b_data_in = 18'h0;
  wire logic              port_b_data_oe_n, ab_empty_n, ab_almost_empty_n, ab_almost_full_n, ab_full_n;
  wire logic              ba_empty_n, ba_almost_empty_n, ba_almost_full_n, ba_full_n, port_b_bypass_indicator_n;
  logic [3:0]             cnt_b = 4'h0;
  logic [DATA_W-1:0]      q;
  int                     n_fail = 0;
  int                     total_checks = 0;
  int                     cycles = 0;
  assign hready = hreadyout;
  bififo_port_b #(.DEPTH(DEPTH)) i_bififo_port_b (.*);
  bififo_port_a_master i_bififo_port_a_master (.*);
  // System clock
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Port B clock, high 4 and low 6 cycles, and the run limit
  always @(posedge hclk)
  begin
    cnt_b <= (cnt_b == 4'h9) ? 4'h0 : cnt_b + 4'h1;
    port_b_clock <= (cnt_b < 4'h4);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Single word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hwrite <= wr;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check($sformatf("reg %h", a), v, exp);
    check("hresp", hresp, 1'b0);
  endtask
  // Port B transfer over one rising edge, then released
  task automatic pb(input logic en_n, input logic dir, input logic [DATA_W-1:0] d);
    do @(posedge hclk); while (cnt_b != 4'h6);
    port_b_enable_n <= en_n;
    port_b_direction <= dir;
    port_b_output_enable_n <= ~dir;
    port_b_data_in <= dir ? ~port_b_data_in : d;
    do @(posedge hclk); while (cnt_b != 4'h6);
    q = port_b_data_oe_n ? ~port_b_data_out : port_b_data_out;
    port_b_enable_n <= 1'b1;
    port_b_data_in <= ~port_b_data_in;
  endtask
  task automatic settle;
    repeat (30) @(posedge hclk);
  endtask
  function automatic logic [8:0] flags();
    return {ab_empty_n, ab_almost_empty_n, ab_almost_full_n, ab_full_n, ba_empty_n, ba_almost_empty_n,
            ba_almost_full_n, ba_full_n, port_b_bypass_indicator_n};
  endfunction
  task automatic test_reset;
    check("flags", flags(), 32'h67);
    rchk(STATUS_ADDR, 32'h1cc);
    for (int i = 1; i < 5; i++)
      rchk(8'(4 * i), 32'h8);
    rchk(IRQ_MASK_ADDR, 32'h0);
    wr(8'h20, 32'h1);
    rchk(8'h20, 32'h0);
  endtask
  task automatic test_ab;
    wr(AB_AE_ADDR, 32'h2);
    wr(AB_AF_ADDR, 32'h3);
    wr(IRQ_MASK_ADDR, 32'h2);
    for (int i = 0; i <= DEPTH; i++)
    begin
      i_bififo_port_a_master.op(1'b0, 18'(i * 5 + 1), q);
      check("ab_full_n", ab_full_n, i + 1 < DEPTH);
      check("ab_almost_full_n", ab_almost_full_n, i + 4 <= DEPTH);
    end
    check("irq masked", irq, 1'b0);
    pb(1'b1, 1'b1, 18'h0);
    settle;
    check("ab_empty_n", ab_empty_n, 1'b1);
    check("ab_full_n", ab_full_n, 1'b0);
    for (int i = 0; i <= DEPTH; i++)
    begin
      pb(1'b0, 1'b1, 18'h0);
      if (i < DEPTH)
        check("port_b_data", q, 18'(i * 5 + 1));
      check("ab_empty_n", ab_empty_n, i + 1 < DEPTH);
      check("ab_almost_empty_n", ab_almost_empty_n, i + 3 < DEPTH);
    end
    rchk(IRQ_STAT_ADDR, 32'h3);
    check("irq", irq, 1'b1);
    wr(IRQ_STAT_ADDR, 32'h3);
    rchk(IRQ_STAT_ADDR, 32'h0);
    check("irq", irq, 1'b0);
  endtask
  task automatic test_ba;
    for (int i = 0; i <= DEPTH; i++)
    begin
      pb(1'b0, 1'b0, 18'(3 * i + 7));
      check("ba_full_n", ba_full_n, i + 1 < DEPTH);
      check("ba_almost_full_n", ba_almost_full_n, i + 9 <= DEPTH);
      check("port_b_data_oe_n", port_b_data_oe_n, 1'b1);
    end
    settle;
    check("ba_empty_n", ba_empty_n, 1'b1);
    for (int i = 0; i <= DEPTH; i++)
    begin
      i_bififo_port_a_master.op(1'b1, 18'h0, q);
      if (i < DEPTH)
        check("port_a_data", q, 18'(3 * i + 7));
      check("ba_empty_n", ba_empty_n, i + 1 < DEPTH);
      check("ba_almost_empty_n", ba_almost_empty_n, i + 9 < DEPTH);
    end
    rchk(IRQ_STAT_ADDR, 32'hc);
    wr(IRQ_STAT_ADDR, 32'hc);
  endtask
  task automatic test_bypass;
    wr(CTRL_ADDR, 32'h1);
    settle;
    check("bypass_n", port_b_bypass_indicator_n, 1'b0);
    i_bififo_port_a_master.op(1'b0, 18'h2a5a5, q);
    settle;
    check("ab full,empty", {ab_full_n, ab_empty_n}, 2'b01);
    pb(1'b0, 1'b1, 18'h0);
    check("bypass b data", q, 18'h2a5a5);
    settle;
    check("ab full,empty", {ab_full_n, ab_empty_n}, 2'b10);
    pb(1'b0, 1'b0, 18'h15a5a);
    settle;
    check("ba full,empty", {ba_full_n, ba_empty_n}, 2'b01);
    i_bififo_port_a_master.op(1'b1, 18'h0, q);
    check("bypass a data", q, 18'h15a5a);
    settle;
    check("ba full,empty", {ba_full_n, ba_empty_n}, 2'b10);
    wr(CTRL_ADDR, 32'h0);
    settle;
    check("bypass_n", port_b_bypass_indicator_n, 1'b1);
  endtask
  task automatic test_rst;
    wr(AB_AE_ADDR, 32'h2);
    i_bififo_port_a_master.op(1'b0, 18'h1, q);
    pb(1'b0, 1'b0, 18'h2);
    settle;
    check("ab_empty_n", ab_empty_n, 1'b1);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    check("flags in reset", flags(), 32'h67);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rchk(STATUS_ADDR, 32'h1cc);
    rchk(AB_AE_ADDR, 32'h8);
  endtask
  // Main sequence
  initial
  begin
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    test_reset;
    test_ab;
    test_ba;
    test_bypass;
    test_rst;
    finish_test;
  end
endmodule // bififo_port_b_test
`default_nettype wire
